// >>> rtl/sls_defines.vh
`ifndef SLS_DEFINES_VH
`define SLS_DEFINES_VH

// Register byte offsets on the Avalon slave
`define SLS_ADDR_W        4
`define SLS_OFS_STATUS    4'h0
`define SLS_OFS_CTRL      4'h4
`define SLS_OFS_IRQ_STAT  4'h8
`define SLS_OFS_IRQ_MASK  4'hC

// Status register field positions
`define SLS_RXCNT_HI      28
`define SLS_RXCNT_LO      24
`define SLS_TXCNT_HI      20
`define SLS_TXCNT_LO      16
`define SLS_FRAME_ERROR_FLAG_BIT    12
`define SLS_ACTIVE_BIT    11
`define SLS_UNDERRUN_BIT  8
`define SLS_SHEMPTY_BIT   7
`define SLS_OVFL_BIT      6
`define SLS_RXEMPTY_BIT   5
`define SLS_TXEMPTY_BIT   3
`define SLS_TXFULL_BIT    1
`define SLS_RXFULL_BIT    0

// Control register fields
`define SLS_CTRL_ON_BIT   0
`define SLS_CTRL_DEEP_BIT 1
`define SLS_CTRL_FRM_BIT  2
`define SLS_CTRL_W        3
`define SLS_CTRL_RESET    3'h0

// Interrupt event bits
`define SLS_IRQ_W         4
`define SLS_IRQ_FRAME_ERROR_FLAG    0
`define SLS_IRQ_UNDERRUN  1
`define SLS_IRQ_OVFL      2
`define SLS_IRQ_RXWORD    3
`define SLS_IRQ_RESET     4'h0

// Buffer geometry
`define SLS_DEPTH         16
`define SLS_PTR_W         4
`define SLS_CNT_W         5
`define SLS_SHALLOW_DEPTH 5'h01

`define SLS_ZERO32        32'h00000000

`endif

// >>> rtl/sls_queue_track.v
`timescale 1ns/1ps
`default_nettype none
`include "sls_defines.vh"

module sls_queue_track #(
    parameter PTR_W = `SLS_PTR_W,
    parameter CNT_W = `SLS_CNT_W,
    parameter DEPTH = `SLS_DEPTH
) (
    input  wire             mclk,
    input  wire             rst,
    input  wire             clear,
    input  wire             deep,
    input  wire             push,
    input  wire             pop,
    output wire             push_ok,
    output wire             pop_ok,
    output reg  [PTR_W:0]   write_pointer,
    output reg  [PTR_W:0]   read_pointer,
    output wire [CNT_W-1:0] count,
    output wire             empty,
    output wire             full
);
    localparam [CNT_W-1:0] DEPTH_C = DEPTH;

    // Extra pointer bit keeps equal pointers meaning empty, never full
    assign empty   = (read_pointer == write_pointer);
    assign count   = write_pointer - read_pointer;
    // Without deep buffering only one word fits
    assign full    = deep ? (count == DEPTH_C) : (count >= `SLS_SHALLOW_DEPTH);
    assign push_ok = push & ~full;
    assign pop_ok  = pop & ~empty;

    // Pointer update; a dropped receive push is reported by the caller, a dropped transmit push is not
    always @(posedge mclk) begin
        if (rst || clear) begin
            write_pointer <= {(PTR_W+1){1'b0}};
            read_pointer  <= {(PTR_W+1){1'b0}};
        end else begin
            if (push_ok)
                write_pointer <= write_pointer + 1'b1;
            if (pop_ok)
                read_pointer <= read_pointer + 1'b1;
        end
    end
endmodule

`default_nettype wire

// >>> rtl/sls_irq.v
`timescale 1ns/1ps
`default_nettype none
`include "sls_defines.vh"

module sls_irq #(
    parameter W = `SLS_IRQ_W
) (
    input  wire         mclk,
    input  wire         rst,
    input  wire [W-1:0] event_in,
    input  wire         clr_we,
    input  wire [W-1:0] clr_data,
    input  wire         mask_we,
    input  wire [W-1:0] mask_data,
    output wire [W-1:0] irq_status,
    output reg  [W-1:0] irq_mask,
    output wire         irq
);
    genvar i;
    // One sticky bit per event; a set in the clear cycle wins
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg sticky;
            always @(posedge mclk) begin
                if (rst)
                    sticky <= 1'b0;
                else if (event_in[i])
                    sticky <= 1'b1;
                else if (clr_we && clr_data[i])
                    sticky <= 1'b0;
            end
            assign irq_status[i] = sticky;
        end
    endgenerate

    // Mask register, a one lets the bit through
    always @(posedge mclk) begin
        if (rst)
            irq_mask <= `SLS_IRQ_RESET;
        else if (mask_we)
            irq_mask <= mask_data;
    end

    assign irq = |(irq_status & irq_mask);
endmodule

`default_nettype wire

// >>> rtl/sls_top.v
// Summary of operation
// - Status bits 28-24 show receive buffer word count, meaningful in deep mode.
// - Status bits 20-16 show transmit buffer word count, meaningful in deep mode.
// - Frame error sets bit 12 in framed mode; software clears it.
// - Bit 11 is high while a transfer runs, low when idle.
// - Framed transmit underrun sets bit 8; only a module disable clears it.
// - Bit 7 is high when the shift register is empty, in deep mode.
// - Bit 6 sets when a received word is dropped because the buffer was full.
// - Only hardware sets bit 6; software clears it by writing zero.
// - Bit 5 is high when receive read and write pointers match, in deep mode only.
`timescale 1ns/1ps
`default_nettype none
`include "sls_defines.vh"

module sls_top #(
    parameter DEPTH = `SLS_DEPTH,
    parameter PTR_W = `SLS_PTR_W,
    parameter CNT_W = `SLS_CNT_W
) (
    input  wire                  mclk,
    input  wire                  rst,
    // Avalon-MM slave
    input  wire [`SLS_ADDR_W-1:0] avs_address,
    input  wire                  avs_read,
    input  wire                  avs_write,
    input  wire [31:0]           avs_writedata,
    output reg  [31:0]           avs_readdata,
    output wire                  avs_waitrequest,
    // Events from the rest of the serial unit
    input  wire                  rx_word_done,
    input  wire                  rx_word_read,
    input  wire                  tx_word_write,
    input  wire                  tx_word_pull,
    input  wire                  shifter_loaded,
    input  wire                  frame_sync_err,
    // Outputs to the rest of the unit
    output wire                  module_on,
    output wire                  deep_buffer_mode,
    output wire                  framed_mode_enable,
    output wire                  rx_push_ok,
    output wire                  tx_pop_ok,
    output wire [PTR_W:0]        rx_read_pointer,
    output wire [PTR_W:0]        rx_write_pointer,
    output wire [PTR_W:0]        tx_read_pointer,
    output wire [PTR_W:0]        tx_write_pointer,
    output reg                   link_active,
    output wire                  irq
);
    reg  [`SLS_CTRL_W-1:0] ctrl;
    reg                    served;
    reg                    frame_error_flag;
    reg                    tx_underrun_flag;
    reg                    rx_overflow_flag;
    reg  [31:0]            next_readdata;
    reg  [31:0]            status_word;

    wire [CNT_W-1:0]       rx_fill_count;
    wire [CNT_W-1:0]       tx_fill_count;
    wire                   rx_empty_raw;
    wire                   rx_queue_full;
    wire                   tx_queue_empty;
    wire                   tx_queue_full;
    wire                   rx_queue_empty;
    wire                   shifter_empty;
    wire                   clear_queues;
    wire                   access;
    wire                   wr_take;
    wire                   overflow_evt;
    wire                   underrun_evt;
    wire                   frame_error_flag_evt;
    wire [`SLS_IRQ_W-1:0]  irq_status;
    wire [`SLS_IRQ_W-1:0]  irq_mask;
    wire [`SLS_IRQ_W-1:0]  irq_events;

    assign module_on          = ctrl[`SLS_CTRL_ON_BIT];
    assign deep_buffer_mode   = ctrl[`SLS_CTRL_DEEP_BIT];
    assign framed_mode_enable = ctrl[`SLS_CTRL_FRM_BIT];
    // Disabled module drops queued words, as on a real restart
    assign clear_queues       = ~module_on;

    // Receive queue: filled by the shifter, drained by software reads
    sls_queue_track #(
        .PTR_W (PTR_W),
        .CNT_W (CNT_W),
        .DEPTH (DEPTH)
    ) u_rx (
        .mclk          (mclk),
        .rst           (rst),
        .clear         (clear_queues),
        .deep          (deep_buffer_mode),
        .push          (rx_word_done),
        .pop           (rx_word_read),
        .push_ok       (rx_push_ok),
        .pop_ok        (),
        .write_pointer (rx_write_pointer),
        .read_pointer  (rx_read_pointer),
        .count         (rx_fill_count),
        .empty         (rx_empty_raw),
        .full          (rx_queue_full)
    );

    // Transmit queue: filled by software, drained by the shifter
    sls_queue_track #(
        .PTR_W (PTR_W),
        .CNT_W (CNT_W),
        .DEPTH (DEPTH)
    ) u_tx (
        .mclk          (mclk),
        .rst           (rst),
        .clear         (clear_queues),
        .deep          (deep_buffer_mode),
        .push          (tx_word_write),
        .pop           (tx_word_pull),
        .push_ok       (),
        .pop_ok        (tx_pop_ok),
        .write_pointer (tx_write_pointer),
        .read_pointer  (tx_read_pointer),
        .count         (tx_fill_count),
        .empty         (tx_queue_empty),
        .full          (tx_queue_full)
    );

    // Flags that only carry meaning with deep buffering read zero otherwise
    assign rx_queue_empty = deep_buffer_mode & rx_empty_raw;
    assign shifter_empty  = deep_buffer_mode & ~shifter_loaded;

    // Event detection
    assign overflow_evt = rx_word_done & rx_queue_full;
    assign underrun_evt = tx_word_pull & tx_queue_empty & framed_mode_enable;
    assign frame_error_flag_evt   = frame_sync_err & framed_mode_enable;

    // Bus handshake: one wait cycle, so read data is ready when released
    assign access          = avs_read | avs_write;
    assign avs_waitrequest = access & ~served;
    assign wr_take         = avs_write & served;

    always @(posedge mclk) begin
        if (rst)
            served <= 1'b0;
        else
            served <= access & ~served;
    end

    // Control register
    always @(posedge mclk) begin
        if (rst)
            ctrl <= `SLS_CTRL_RESET;
        else if (wr_take && avs_address == `SLS_OFS_CTRL)
            ctrl <= avs_writedata[`SLS_CTRL_W-1:0];
    end

    // Frame error: hardware sets, writing zero clears, set wins
    always @(posedge mclk) begin
        if (rst)
            frame_error_flag <= 1'b0;
        else if (frame_error_flag_evt)
            frame_error_flag <= 1'b1;
        else if (wr_take && avs_address == `SLS_OFS_STATUS &&
                 !avs_writedata[`SLS_FRAME_ERROR_FLAG_BIT])
            frame_error_flag <= 1'b0;
    end

    // Receive overflow: never cleared by hardware itself
    always @(posedge mclk) begin
        if (rst)
            rx_overflow_flag <= 1'b0;
        else if (overflow_evt)
            rx_overflow_flag <= 1'b1;
        else if (wr_take && avs_address == `SLS_OFS_STATUS &&
                 !avs_writedata[`SLS_OVFL_BIT])
            rx_overflow_flag <= 1'b0;
    end

    // Underrun holds until the module is switched off; writes cannot clear it
    always @(posedge mclk) begin
        if (rst)
            tx_underrun_flag <= 1'b0;
        else if (!module_on)
            tx_underrun_flag <= 1'b0;
        else if (underrun_evt)
            tx_underrun_flag <= 1'b1;
    end

    // Busy while the shifter works or words wait to go out
    always @(posedge mclk) begin
        if (rst)
            link_active <= 1'b0;
        else
            link_active <= module_on & (shifter_loaded | ~tx_queue_empty);
    end

    // Interrupt events
    assign irq_events[`SLS_IRQ_FRAME_ERROR_FLAG]   = frame_error_flag_evt;
    assign irq_events[`SLS_IRQ_UNDERRUN] = underrun_evt;
    assign irq_events[`SLS_IRQ_OVFL]     = overflow_evt;
    assign irq_events[`SLS_IRQ_RXWORD]   = rx_push_ok;

    sls_irq #(
        .W (`SLS_IRQ_W)
    ) u_irq (
        .mclk       (mclk),
        .rst        (rst),
        .event_in   (irq_events),
        .clr_we     (wr_take && avs_address == `SLS_OFS_IRQ_STAT),
        .clr_data   (avs_writedata[`SLS_IRQ_W-1:0]),
        .mask_we    (wr_take && avs_address == `SLS_OFS_IRQ_MASK),
        .mask_data  (avs_writedata[`SLS_IRQ_W-1:0]),
        .irq_status (irq_status),
        .irq_mask   (irq_mask),
        .irq        (irq)
    );

    // Status word; unimplemented bits stay zero
    always @* begin
        status_word = `SLS_ZERO32;
        status_word[`SLS_RXCNT_HI:`SLS_RXCNT_LO] = rx_fill_count;
        status_word[`SLS_TXCNT_HI:`SLS_TXCNT_LO] = tx_fill_count;
        status_word[`SLS_FRAME_ERROR_FLAG_BIT]   = frame_error_flag;
        status_word[`SLS_ACTIVE_BIT]   = link_active;
        status_word[`SLS_UNDERRUN_BIT] = tx_underrun_flag;
        status_word[`SLS_SHEMPTY_BIT]  = shifter_empty;
        status_word[`SLS_OVFL_BIT]     = rx_overflow_flag;
        status_word[`SLS_RXEMPTY_BIT]  = rx_queue_empty;
        status_word[`SLS_TXEMPTY_BIT]  = tx_queue_empty;
        status_word[`SLS_TXFULL_BIT]   = tx_queue_full;
        status_word[`SLS_RXFULL_BIT]   = rx_queue_full;
    end

    // Read mux; unmapped offsets answer zero
    always @* begin
        next_readdata = `SLS_ZERO32;
        case (avs_address)
            `SLS_OFS_STATUS:   next_readdata = status_word;
            `SLS_OFS_CTRL:     next_readdata[`SLS_CTRL_W-1:0] = ctrl;
            `SLS_OFS_IRQ_STAT: next_readdata[`SLS_IRQ_W-1:0] = irq_status;
            `SLS_OFS_IRQ_MASK: next_readdata[`SLS_IRQ_W-1:0] = irq_mask;
            default:           next_readdata = `SLS_ZERO32;
        endcase
    end

    // Capture during the wait cycle so data stands at the release edge
    always @(posedge mclk) begin
        if (rst)
            avs_readdata <= `SLS_ZERO32;
        else if (avs_read && !served)
            avs_readdata <= next_readdata;
    end
endmodule

`default_nettype wire

// >>> sim/sls_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sls_checker #(
    parameter DEPTH = 16,
    parameter PTR_W = 4,
    parameter CNT_W = 5
) (
    input wire logic         mclk,
    input wire logic         rst,
    input wire logic         avs_read,
    input wire logic         avs_write,
    input wire logic         avs_waitrequest,
    input wire logic         rx_word_done,
    input wire logic         tx_word_pull,
    input wire logic         shifter_loaded,
    input wire logic         module_on,
    input wire logic         deep_buffer_mode,
    input wire logic         rx_push_ok,
    input wire logic         tx_pop_ok,
    input wire logic [PTR_W:0] rx_read_pointer,
    input wire logic [PTR_W:0] rx_write_pointer,
    input wire logic [PTR_W:0] tx_read_pointer,
    input wire logic [PTR_W:0] tx_write_pointer,
    input wire logic         link_active,
    input wire logic         irq
);
    // Fill levels from the wrap-bit pointers; shallow mode holds one word
    wire [PTR_W:0] rx_used = rx_write_pointer - rx_read_pointer;
    wire [PTR_W:0] tx_used = tx_write_pointer - tx_read_pointer;
    wire [PTR_W:0] rx_cap = deep_buffer_mode ? (PTR_W+1)'(DEPTH) : (PTR_W+1)'(1);

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    bus_wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("wait state longer than one cycle");
    rx_push_step_a: assert property (
        rx_word_done && rx_push_ok && module_on && !avs_write
        |=> rx_write_pointer == $past(rx_write_pointer) + (PTR_W+1)'(1))
        else $error("receive write pointer did not step");
    tx_pop_step_a: assert property (
        tx_word_pull && tx_pop_ok && module_on && !avs_write
        |=> tx_read_pointer == $past(tx_read_pointer) + (PTR_W+1)'(1))
        else $error("transmit read pointer did not step");
    rx_full_refuse_a: assert property (
        rx_word_done && rx_used == rx_cap |-> !rx_push_ok)
        else $error("word accepted into a full receive queue");
    rx_accept_a: assert property (
        rx_word_done && module_on && rx_used < rx_cap |-> rx_push_ok)
        else $error("word refused with room left");
    tx_empty_refuse_a: assert property (
        tx_word_pull && tx_used == 0 |-> !tx_pop_ok)
        else $error("pull served from an empty transmit queue");
    link_busy_a: assert property (1'b1 |=> link_active ==
        $past(module_on && (shifter_loaded || tx_used != 0)))
        else $error("activity flag wrong");
    reset_state_a: assert property ($fell(rst) |-> !module_on && !irq &&
        !link_active && rx_used == 0 && tx_used == 0)
        else $error("state after reset wrong");
endmodule

bind sls_top sls_checker #(.DEPTH(DEPTH), .PTR_W(PTR_W), .CNT_W(CNT_W)) u_chk (
    .mclk(mclk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .rx_word_done(rx_word_done),
    .tx_word_pull(tx_word_pull), .shifter_loaded(shifter_loaded),
    .module_on(module_on), .deep_buffer_mode(deep_buffer_mode),
    .rx_push_ok(rx_push_ok), .tx_pop_ok(tx_pop_ok),
    .rx_read_pointer(rx_read_pointer), .rx_write_pointer(rx_write_pointer),
    .tx_read_pointer(tx_read_pointer), .tx_write_pointer(tx_write_pointer),
    .link_active(link_active), .irq(irq));
`default_nettype wire

// >>> sim/sls_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module sls_far_end (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        en,
    input wire logic        slow,
    input wire logic [31:0] rnd,
    output var logic        rx_word_done,
    output var logic        tx_word_pull,
    output var logic        shifter_loaded,
    output var logic        frame_sync_err
);
    // Quiet at time zero so the design never sees an unknown event
    initial begin
        rx_word_done = 1'b0;
        tx_word_pull = 1'b0;
        shifter_loaded = 1'b0;
        frame_sync_err = 1'b0;
    end

    // Events ride on the bench's random word; slow mode starves the pull side
    always @(posedge mclk) begin
        rx_word_done <= !rst && en && rnd[8];
        tx_word_pull <= !rst && en && rnd[9] && (!slow || rnd[10]);
        shifter_loaded <= !rst && en && rnd[11];
        frame_sync_err <= !rst && en && rnd[12] && rnd[13] && rnd[14];
    end
endmodule
`default_nettype wire

// >>> sim/test_spi_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
module test_spi_status_flags;
    logic        mclk, rst, en, slow, avs_read, avs_write, rx_word_read, tx_word_write;
    logic        fe, ov, un;
    logic [3:0]  avs_address, ist, mask;
    logic [31:0] avs_writedata, rnd, rd;
    logic [4:0]  rc, tc;
    logic [2:0]  ctrl;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest, irq, rx_word_done, tx_word_pull, shifter_loaded;
    wire         frame_sync_err;
    wire  [2:0]  mode_pins;
    integer      error_cnt, n_tests, r;

    sls_top u_dut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rx_word_done(rx_word_done), .rx_word_read(rx_word_read),
        .tx_word_write(tx_word_write), .tx_word_pull(tx_word_pull),
        .shifter_loaded(shifter_loaded), .frame_sync_err(frame_sync_err),
        .module_on(mode_pins[0]), .deep_buffer_mode(mode_pins[1]),
        .framed_mode_enable(mode_pins[2]), .rx_push_ok(),
        .tx_pop_ok(), .rx_read_pointer(), .rx_write_pointer(), .tx_read_pointer(),
        .tx_write_pointer(), .link_active(), .irq(irq));

    sls_far_end u_far (.mclk(mclk), .rst(rst), .en(en), .slow(slow), .rnd(rnd),
        .rx_word_done(rx_word_done), .tx_word_pull(tx_word_pull),
        .shifter_loaded(shifter_loaded), .frame_sync_err(frame_sync_err));

    function logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        xs = x ^ (x << 5);
    endfunction

    function logic [4:0] cap();
        cap = ctrl[1] ? 5'h10 : 5'h01;
    endfunction

    // Expected status word; the shifter is idle whenever software reads
    function logic [31:0] exp_stat();
        exp_stat = 32'h0;
        exp_stat[28:24] = rc;
        exp_stat[20:16] = tc;
        exp_stat[12] = fe;
        exp_stat[11] = ctrl[0] && tc != 5'h00;
        exp_stat[8] = un;
        exp_stat[7] = ctrl[1];
        exp_stat[6] = ov;
        exp_stat[5] = ctrl[1] && rc == 5'h00;
        exp_stat[3] = tc == 5'h00;
        exp_stat[1] = tc == cap();
        exp_stat[0] = rc == cap();
    endfunction

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
            error_cnt = error_cnt + 1;
        end
    endtask

    task print_verdict;
        if (error_cnt == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // One Avalon access; request held until waitrequest is sampled low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) @(posedge mclk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Software-side events from the random word
    always @(posedge mclk) begin
        if (en) rnd <= xs(rnd);
        rx_word_read <= en && rnd[5] && rnd[7];
        tx_word_write <= en && rnd[6];
    end

    // Reference model, fed by the input values seen before each edge
    always @(posedge mclk) begin
        if (rst) begin
            {fe, ov, ist} = 6'h00;
        end
        if (rst || !ctrl[0]) begin
            {rc, tc, un} = 11'h000;
        end else begin
            if (rx_word_done && rc == cap()) {ov, ist[2]} = 2'h3;
            if (rx_word_done && rc != cap()) ist[3] = 1'b1;
            if (tx_word_pull && tc == 5'h00 && ctrl[2]) {un, ist[1]} = 2'h3;
            if (frame_sync_err && ctrl[2]) {fe, ist[0]} = 2'h3;
            rc = rc + (rx_word_done && rc != cap()) - (rx_word_read && rc != 5'h00);
            tc = tc + (tx_word_write && tc != cap()) - (tx_word_pull && tc != 5'h00);
        end
    end

    // Watchdog sized well beyond the expected run of about six hundred cycles
    initial begin
        #400000;
        error_cnt = error_cnt + 1;
        print_verdict;
    end

    initial begin
        {error_cnt, n_tests, en, slow, avs_read, avs_write} = 0;
        {rx_word_read, tx_word_write, avs_address, avs_writedata} = 0;
        {ctrl, ist} = 0;
        rnd = 32'h00005D64;
        rst = 1'b1;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        bus(0, 4'h0, 32'h0);
        check("status_rst", rd, 32'h00000008);
        bus(1, 4'h6, 32'hFFFFFFFF);
        bus(0, 4'h6, 32'h0);
        check("unmapped", rd, 32'h0);
        bus(0, 4'hC, 32'h0);
        check("mask_rst", rd, 32'h0);
        for (r = 0; r < 8; r = r + 1) begin
            mask = rnd[3:0];
            ctrl = {r[1:0], 1'b1};
            slow <= r[2];
            bus(1, 4'h4, {29'h0, ctrl});
            bus(0, 4'h4, 32'h0);
            check("ctrl", rd, {29'h0, ctrl});
            check("mode_pins", {29'h0, mode_pins}, {29'h0, ctrl});
            bus(1, 4'hC, {28'h0, mask});
            en <= 1'b1;
            repeat (40) @(posedge mclk);
            en <= 1'b0;
            repeat (3) @(posedge mclk);
            bus(0, 4'h0, 32'h0);
            check("status", rd, exp_stat());
            bus(0, 4'h8, 32'h0);
            check("irq_status", rd, {28'h0, ist});
            check("irq", {31'h0, irq}, {31'h0, |(ist & mask)});
            // Writing ones must not set any flag; underrun survives a zero write
            bus(1, 4'h0, 32'hFFFFFFFF);
            bus(0, 4'h0, 32'h0);
            check("status_ones", rd, exp_stat());
            bus(1, 4'h0, 32'h0);
            {fe, ov} = 2'h0;
            bus(1, 4'h8, 32'h0000000F);
            ist = 4'h0;
            ctrl = 3'h0;
            bus(1, 4'h4, 32'h0);
            bus(0, 4'h0, 32'h0);
            check("status_off", rd, exp_stat());
            check("mode_off", {29'h0, mode_pins}, 32'h0);
        end
        print_verdict;
    end
endmodule
`default_nettype wire
